// file: core/tsense_serial_slave.sv
// Purpose: two-wire slave port of a temperature sensor with open-drain alert
// Assumes: host makes the serial clock; both lines have external pull-ups
// Notes: register contents live outside; this block moves bytes to and from them
`timescale 1ns/1ps
// How it works
// [RULE1] two-wire slave: serial clock input plus one bidirectional data line
// [RULE2] host makes the serial clock; this port never drives it
// [RULE3] bits sampled on clock rise, data launched after clock fall only
// [RULE4] data line driven only low; released line reads high via pull-up
// [RULE5] upper four address bits are fixed at 1001
// [RULE6] lower three address bits come from strap pins bit2, bit1, bit0
// [RULE7] alert asserts while temperature is beyond the programmed limit
// [RULE8] alert is open drain: pulled low or released, never driven high
// [RULE9] after start compare address, ack on match, eighth bit one means read
// [RULE10] a new start abandons any transfer and begins a fresh access
// [RULE11] a stop releases the data line, even mid transfer
// [RULE12] receiver acks each byte; host nak on last read byte, line stays released
// [RULE13] clock and data synchronised and deglitched before edge detection
module tsense_serial_slave (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n_out,
   input wire logic addr_strap_bit2_in,
   input wire logic addr_strap_bit1_in,
   input wire logic addr_strap_bit0_in,
   input wire logic over_limit_in,
   output logic alert_out,
   output logic alert_oe_n_out,
   input wire logic [7:0] tx_data_in,
   output logic tx_req_out,
   output logic [7:0] rx_data_out,
   output logic rx_valid_out,
   output logic rx_first_out,
   output logic busy_out
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_DATA,
      ST_WR_ACK,
      ST_RD_DATA,
      ST_RD_ACK
   } phase_t;

   typedef struct packed {
      phase_t phase;
      logic scl_prev;
      logic sda_prev;
      logic [2:0] bit_idx;
      logic [7:0] shift;
      logic bit_seen;
      logic sda_low;
      logic first_wr;
      logic [7:0] rx_data;
      logic rx_valid;
      logic rx_first;
      logic tx_req;
      logic alert_low;
      logic [2:0] strap_m;
      logic [2:0] strap_s;
      logic over_m;
      logic over_s;
   } port_state_t;

   port_state_t st_q;
   port_state_t st_d;
   logic scl_f;
   logic sda_f;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [6:0] own_addr;

   line_filter u_scl_filter ( // RULE13
      .clk_in(clk_in),
      .srst_in(srst_in),
      .line_in(scl_in),
      .line_out(scl_f)
   );

   line_filter u_sda_filter ( // RULE13
      .clk_in(clk_in),
      .srst_in(srst_in),
      .line_in(sda_in),
      .line_out(sda_f)
   );

   assign scl_rise = scl_f & ~st_q.scl_prev; // RULE3
   assign scl_fall = ~scl_f & st_q.scl_prev; // RULE3
   assign start_seen = scl_f & st_q.scl_prev & st_q.sda_prev & ~sda_f;
   assign stop_seen = scl_f & st_q.scl_prev & ~st_q.sda_prev & sda_f;
   assign own_addr = {tsense_pkg::FIXED_ADDR_UPPER_NIBBLE, st_q.strap_s}; // RULE5 RULE6

   always_comb begin
      st_d = st_q;
      st_d.scl_prev = scl_f;
      st_d.sda_prev = sda_f;
      st_d.rx_valid = 1'b0;
      st_d.tx_req = 1'b0;
      // straps and the limit flag come from outside this clock; two flops each
      st_d.strap_m = {addr_strap_bit2_in, addr_strap_bit1_in, addr_strap_bit0_in}; // RULE6
      st_d.strap_s = st_q.strap_m;
      st_d.over_m = over_limit_in;
      st_d.over_s = st_q.over_m;
      st_d.alert_low = st_q.over_s; // RULE7
      if (start_seen) begin
         // repeated start restarts cleanly from the address byte
         st_d.phase = ST_ADDR; // RULE10
         st_d.bit_idx = tsense_pkg::BIT_FIRST;
         st_d.bit_seen = 1'b0;
         st_d.sda_low = 1'b0;
      end else if (stop_seen) begin
         st_d.phase = ST_IDLE; // RULE11
         st_d.sda_low = 1'b0; // RULE11
      end else begin
         case (st_q.phase)
            ST_IDLE: begin
               st_d.sda_low = 1'b0;
            end
            ST_ADDR, ST_WR_DATA: begin
               // the clock fall that closes a start carries no bit, so a fall
               // only counts once a rise has shifted something in
               if (scl_rise) begin
                  st_d.shift = {st_q.shift[6:0], sda_f}; // RULE3
                  st_d.bit_seen = 1'b1;
               end else if (scl_fall && st_q.bit_seen && st_q.bit_idx == tsense_pkg::BIT_LAST) begin
                  st_d.bit_seen = 1'b0;
                  if (st_q.phase == ST_ADDR) begin
                     st_d.phase = ST_ADDR_ACK;
                     st_d.sda_low = (st_q.shift[7:1] == own_addr); // RULE9
                     if (st_q.shift[7:1] != own_addr) begin
                        st_d.phase = ST_IDLE; // RULE9
                     end
                  end else begin
                     st_d.phase = ST_WR_ACK;
                     st_d.sda_low = 1'b1; // RULE12
                     st_d.rx_data = st_q.shift;
                     st_d.rx_valid = 1'b1;
                     st_d.rx_first = st_q.first_wr;
                     st_d.first_wr = 1'b0;
                  end
               end else if (scl_fall && st_q.bit_seen) begin
                  st_d.bit_seen = 1'b0;
                  st_d.bit_idx = st_q.bit_idx - 3'h1;
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  st_d.bit_idx = tsense_pkg::BIT_FIRST;
                  if (st_q.shift[0] == tsense_pkg::RW_READ) begin // RULE9
                     st_d.phase = ST_RD_DATA;
                     st_d.shift = tx_data_in;
                     st_d.tx_req = 1'b1;
                     st_d.sda_low = ~tx_data_in[7]; // RULE4
                  end else begin
                     st_d.phase = ST_WR_DATA;
                     st_d.first_wr = 1'b1;
                     st_d.sda_low = 1'b0;
                  end
               end
            end
            ST_WR_ACK: begin
               if (scl_fall) begin
                  st_d.phase = ST_WR_DATA;
                  st_d.bit_idx = tsense_pkg::BIT_FIRST;
                  st_d.sda_low = 1'b0;
               end
            end
            ST_RD_DATA: begin
               if (scl_fall) begin
                  if (st_q.bit_idx == tsense_pkg::BIT_LAST) begin
                     st_d.phase = ST_RD_ACK;
                     st_d.sda_low = 1'b0; // RULE12
                  end else begin
                     st_d.bit_idx = st_q.bit_idx - 3'h1;
                     st_d.shift = {st_q.shift[6:0], 1'b0};
                     st_d.sda_low = ~st_q.shift[6]; // RULE4
                  end
               end
            end
            ST_RD_ACK: begin
               if (scl_rise && sda_f) begin
                  st_d.phase = ST_IDLE; // RULE12
               end else if (scl_fall) begin
                  // host acked: send the same register again
                  st_d.phase = ST_RD_DATA;
                  st_d.bit_idx = tsense_pkg::BIT_FIRST;
                  st_d.shift = tx_data_in;
                  st_d.tx_req = 1'b1;
                  st_d.sda_low = ~tx_data_in[7]; // RULE4
               end
            end
            default: begin
               st_d.phase = ST_IDLE;
               st_d.sda_low = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         st_q <= '{phase: ST_IDLE, scl_prev: 1'b1, sda_prev: 1'b1,
                   bit_idx: tsense_pkg::BIT_FIRST, shift: 8'h00, bit_seen: 1'b0,
                   sda_low: 1'b0, first_wr: 1'b0, rx_data: 8'h00,
                   rx_valid: 1'b0, rx_first: 1'b0, tx_req: 1'b0, alert_low: 1'b0,
                   strap_m: 3'h0, strap_s: 3'h0, over_m: 1'b0, over_s: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   // the serial clock is never driven here; only data and alert have drivers
   assign sda_out = 1'b0; // RULE4 RULE1 RULE2
   assign sda_oe_n_out = ~st_q.sda_low; // RULE4
   assign alert_out = 1'b0; // RULE8
   assign alert_oe_n_out = ~st_q.alert_low; // RULE8
   assign rx_data_out = st_q.rx_data;
   assign rx_valid_out = st_q.rx_valid;
   assign rx_first_out = st_q.rx_first;
   assign tx_req_out = st_q.tx_req;
   assign busy_out = (st_q.phase != ST_IDLE);
endmodule // tsense_serial_slave

// file: inc/tsense_pkg.sv
// Purpose: shared constants for the temperature sensor serial slave port
// Assumes: 200 MHz core clock, serial clock and data sampled as plain inputs
// Notes: timing figures are kept in ns and turned into cycle counts here
package tsense_pkg;
   localparam int unsigned CLK_PERIOD_NS = 5;
   // glitch filter span: shortest serial clock high time is 600 ns
   localparam int unsigned FILTER_NS = 50;
   localparam int unsigned FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] FILTER_CNT = 4'(FILTER_CYC);
   localparam logic [3:0] FIXED_ADDR_UPPER_NIBBLE = 4'h9;
   localparam logic [2:0] BIT_LAST = 3'h0;
   localparam logic [2:0] BIT_FIRST = 3'h7;
   localparam logic RW_READ = 1'b1;
endpackage

// file: core/line_filter.sv
// Purpose: two-flop synchroniser plus stable-count deglitch for one bus line
// Assumes: line idles high behind a pull-up
// Notes: output changes only after the input has held a new level FILTER_CNT cycles
`timescale 1ns/1ps
module line_filter (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic line_in,
   output logic line_out
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic level;
      logic [3:0] cnt;
   } filt_state_t;

   filt_state_t st_q;
   filt_state_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.meta = line_in;
      st_d.sync = st_q.meta;
      if (st_q.sync == st_q.level) begin
         st_d.cnt = 4'h0;
      end else if (st_q.cnt == tsense_pkg::FILTER_CNT - 4'h1) begin
         st_d.level = st_q.sync;
         st_d.cnt = 4'h0;
      end else begin
         st_d.cnt = st_q.cnt + 4'h1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         st_q <= '{meta: 1'b1, sync: 1'b1, level: 1'b1, cnt: 4'h0};
      end else begin
         st_q <= st_d;
      end
   end

   assign line_out = st_q.level;
endmodule // line_filter

// file: test/tsense_serial_slave_sva.sv
// Purpose: port checks for the serial slave
// Assumes: sda_in is the resolved wire level
// Notes: start and stop are seen on the raw lines
`timescale 1ns/1ps
module tsense_serial_slave_sva (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n_out,
   input wire logic over_limit_in,
   input wire logic alert_oe_n_out,
   input wire logic rx_valid_out,
   input wire logic busy_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   sequence s_start; scl_in && $fell(sda_in); endsequence
   sequence s_stop; scl_in && $rose(sda_in); endsequence
   a_sda_low: assert property (!sda_oe_n_out |-> (!sda_out && busy_out))
      else $error("sda driven high or while idle");
   a_alert_set: assert property (over_limit_in |-> ##3 !alert_oe_n_out)
      else $error("alert late");
   a_alert_clr: assert property (!over_limit_in |-> ##3 alert_oe_n_out)
      else $error("alert stuck");
   a_drive_low: assert property ($fell(sda_oe_n_out) |-> !scl_in) else $error("drive");
   a_start_busy: assert property (s_start |-> ##[1:20] busy_out) else $error("start");
   a_stop_free: assert property (s_stop |-> ##[1:20] (!busy_out && sda_oe_n_out))
      else $error("stop");
   a_byte_ack: assert property (rx_valid_out |-> ##[0:20] !sda_oe_n_out) else $error("ack");
   a_rx_pulse: assert property (rx_valid_out |=> !rx_valid_out) else $error("rx");
endmodule // tsense_serial_slave_sva
bind tsense_serial_slave tsense_serial_slave_sva u_sva (.clk_in, .srst_in, .scl_in, .sda_in,
   .sda_out, .sda_oe_n_out, .over_limit_in, .alert_oe_n_out, .rx_valid_out, .busy_out);

// file: test/host_master.sv
// Purpose: host master model owning the serial clock
// Assumes: bench adds the data line pull-up
// Notes: phases of 24 cycles outlast the deglitch span
`timescale 1ns/1ps
module host_master (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   initial {scl_out, sda_low_out} = 2'b10;
   task automatic ph(input logic c, input logic l);
      repeat (24) @(posedge clk_in);
      scl_out <= c;
      sda_low_out <= l;
   endtask
   task automatic bitx(input logic b, output logic r);
      ph(1'b0, !b);
      ph(1'b1, !b);
      ph(1'b1, !b);
      r = sda_in;
      ph(1'b0, !b);
   endtask
   task automatic cond(input logic [7:0] v);
      for (int i = 3; i >= 0; i--) ph(v[2*i+1], v[2*i]);
   endtask
endmodule // host_master

// file: test/temp_sensor_serial_slave_port_tb_top.sv
// Purpose: self-checking bench for the serial slave port
// Assumes: pull-up modelled on the data line only; alert checked at its output enable
// Notes: straps stepped through 0 to 7; bytes and alert levels random from a fixed seed
`timescale 1ns/1ps
module temp_sensor_serial_slave_port_tb_top;
   localparam logic [7:0] start_c = 8'h2d, stop_c = 8'h7a;
   logic clk = 1'b0, srst = 1'b1, ol = 1'b0, scl, hl, k, rf, oe_n, aoe_n, bsy, treq, aout;
   logic [2:0] sp = 3'h0;
   logic [7:0] tx = 8'h00, t, r, rxd;
   int fail_count = 0, n_compared = 0, n_req = 0;
   wire sda = !(hl || !oe_n);
   always #2.5 clk = !clk;
   // read bytes handed out, counted on the clock so each one-cycle pulse counts once
   always @(posedge clk) begin
      if (treq === 1'b1) n_req++;
   end
   host_master h (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(hl));
   tsense_serial_slave DUT (.clk_in(clk), .srst_in(srst), .scl_in(scl), .sda_in(sda),
      .sda_out(), .sda_oe_n_out(oe_n), .addr_strap_bit2_in(sp[2]), .addr_strap_bit1_in(sp[1]),
      .addr_strap_bit0_in(sp[0]), .over_limit_in(ol), .alert_out(aout), .alert_oe_n_out(aoe_n),
      .tx_data_in(tx), .tx_req_out(treq), .rx_data_out(rxd), .rx_valid_out(), .rx_first_out(rf),
      .busy_out(bsy));
   function automatic logic [7:0] ab(input logic [2:0] s, input logic rd);
      return {4'h9, s, rd};
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) fail_count++;
      if (g !== e) $display("Error at %0t: got %h expected %h", $time, g, e);
   endtask
   task automatic xb(input logic [7:0] d, input logic a9);
      for (int i = 7; i >= 0; i--) h.bitx(d[i], r[i]);
      h.bitx(a9, k);
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      // the scenarios need about 34200 cycles; this leaves ample margin
      repeat (60000) @(posedge clk);
      fail_count++;
      results();
   end
   initial begin
      void'($urandom(32'h7620ccc7));
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      for (int s = 0; s < 8; s++) begin
         sp <= 3'(s);
         ol <= 1'($urandom);
         t = 8'($urandom);
         h.cond(start_c);
         xb(ab(3'(s), 1'b0), 1'b1);
         chk(16'(k), 16'h0);
         xb(t, 1'b1);
         chk({rxd, 6'h0, k, rf}, {t, 8'h1});
         xb(~t, 1'b1);
         chk({rxd, 6'h0, k, rf}, {~t, 8'h0});
         chk(16'({aout, aoe_n}), 16'({1'b0, !ol}));
         h.cond(start_c);
         xb(ab(3'(s), 1'b0) ^ (s[0] ? 8'h80 >> s[2:1] : 8'h02 << s[2:1]), 1'b1);
         chk(16'(k), 16'h1);
         h.cond(stop_c);
      end
      tx <= 8'($urandom) | 8'h08;
      h.cond(start_c);
      xb(ab(3'h7, 1'b1), 1'b1);
      chk(16'(k), 16'h0);
      xb(8'hff, 1'b1);
      chk({r, 7'h0, k}, {tx, 8'h1});
      chk(16'(n_req), 16'h1);
      h.cond(stop_c);
      h.cond(start_c);
      xb(ab(3'h7, 1'b1), 1'b1);
      chk(16'(k), 16'h0);
      xb(8'hff, 1'b0);
      chk(16'(r), 16'(tx));
      repeat (4) h.bitx(1'b1, k);
      h.cond(stop_c);
      chk({7'h0, oe_n, 7'h0, bsy}, 16'h100);
      chk(16'(n_req), 16'h3);
      results();
   end
endmodule // temp_sensor_serial_slave_port_tb_top
